// >>> rtl/firsc_top.sv
// Status and control register bank of the fast infrared transmit and receive paths
//
// Added by the designer: the address-and-strobe port.
module firsc_top
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic srst_in,
   // Register port
   input wire firsc_pkg::firsc_bus_t bus_in,
   output logic [7:0] rdata_out,
   // Transmit datapath
   input wire firsc_pkg::firsc_tx_in_t tx_in,
   output logic tx_dma_start_out,
   output logic tx_irq_out,
   // Receive datapath
   input wire firsc_pkg::firsc_rx_in_t rx_in,
   input wire logic rx_pin_in,
   output logic rx_enable_out,
   output logic rx_crc_check_en_out,
   output logic [1:0] rx_addr_mode_out,
   output logic [2:0] rx_entry_status_out,
   output logic rx_queue_ready_out,
   output logic rx_irq_out
);
   import firsc_pkg::*;

   firsc_state_t q;
   firsc_state_t n;
   logic [10:0] ew_cnt;
   logic [7:0] tx_stat;
   logic [7:0] rx_stat;
   logic clr_tx_cmd;
   logic rx_spec_cmd;
   logic rd_tx;
   logic rd_rx;
   logic ew_hit;
   logic ready_now;
   logic sync_bit;

   // Early warning count lookup
   always_comb
   begin
      case (q.tc2[2:0])
         3'h1: ew_cnt = EW_CNT_1;
         3'h2: ew_cnt = EW_CNT_2;
         3'h3: ew_cnt = EW_CNT_3;
         3'h4: ew_cnt = EW_CNT_4;
         3'h5: ew_cnt = EW_CNT_5;
         3'h6: ew_cnt = EW_CNT_6;
         3'h7: ew_cnt = EW_CNT_7;
         default: ew_cnt = 11'h000;
      endcase
   end

   // Decode of strobes, commands and status words
   always_comb
   begin
      rd_tx = bus_in.rd && (bus_in.addr == ADDR_TX_STAT);
      rd_rx = bus_in.rd && (bus_in.addr == ADDR_RX_STAT);
      clr_tx_cmd = bus_in.wr && (bus_in.addr == ADDR_RST_CMD)
         && (bus_in.wdata[7:CMD_POS] == CMD_CLR_TX);
      rx_spec_cmd = bus_in.wr && (bus_in.addr == ADDR_RST_CMD)
         && (bus_in.wdata[7:CMD_POS] == CMD_RX_SPECIAL);
      // Crossing into the programmed level, not sitting on it
      ew_hit = (q.tc2[2:0] != 3'h0) && (tx_in.byte_count == ew_cnt)
         && (q.prev_cnt != ew_cnt);
      ready_now = !tx_in.fifo_full;
      tx_stat = {4'h0, q.underrun, q.done, ready_now, q.early};
      // Live sync signal when its interrupt is off
      sync_bit = q.rxc[RC_SYNC_IE] ? q.sync_chg : rx_in.sync_hunt;
      rx_stat = {rx_in.top_status[2], rx_in.top_status[1], q.overrun,
         rx_in.top_status[0], (rx_in.fifo_level != 5'd0), sync_bit,
         q.pin_s2, 1'b0};
   end

   // Next state
   always_comb
   begin
      n = q;
      n.pin_s1 = rx_pin_in;
      n.pin_s2 = q.pin_s1;
      n.prev_cnt = tx_in.byte_count;
      // Register writes
      if (bus_in.wr)
      begin
         case (bus_in.addr)
            ADDR_MISC: n.misc = bus_in.wdata & MISC_MASK;
            ADDR_TX_CTL1: n.tc1 = bus_in.wdata;
            ADDR_TX_CTL2: n.tc2 = bus_in.wdata;
            ADDR_RX_CTL: n.rxc = bus_in.wdata & RX_CTL_MASK;
            default: n.misc = q.misc;
         endcase
      end
      // Read data for the next cycle
      n.rdata = 8'h00;
      if (bus_in.rd)
      begin
         case (bus_in.addr)
            ADDR_MISC: n.rdata = q.misc;
            ADDR_TX_CTL1: n.rdata = q.tc1;
            ADDR_TX_CTL2: n.rdata = q.tc2;
            ADDR_TX_STAT: n.rdata = tx_stat;
            ADDR_RX_CTL: n.rdata = q.rxc;
            ADDR_RX_STAT: n.rdata = rx_stat;
            default: n.rdata = 8'h00;
         endcase
      end
      // Underrun latch, set wins over the command
      if (clr_tx_cmd)
         n.underrun = 1'b0;
      if (tx_in.fifo_empty && (tx_in.byte_count != 11'h000))
         n.underrun = 1'b1;
      // Packet done latch
      if (clr_tx_cmd)
         n.done = 1'b0;
      if (rd_tx && q.tc1[TC1_AUTO_CLR])
         n.done = 1'b0;
      if (tx_in.packet_done)
         n.done = 1'b1;
      // Early warning latch
      if (rd_tx)
         n.early = 1'b0;
      if (ew_hit)
         n.early = 1'b1;
      // Queue ready event on rising not-full
      n.ready_q = ready_now;
      if (rd_tx)
         n.ready_evt = 1'b0;
      if (ready_now && !q.ready_q)
         n.ready_evt = 1'b1;
      // Next packet DMA on done falling
      n.dma_start = q.done && !n.done && q.misc[MISC_TX_EN]
         && q.misc[MISC_DMA_CONN];
      // Transmit interrupt
      n.tx_irq = (q.tc1[TC1_DONE_IE] && (q.underrun
         || ((q.tc2[2:0] == 3'h0) ? q.done : q.early)))
         || (q.tc1[TC1_READY_IE] && q.ready_evt);
      // Sync change latch, read clears only while its interrupt is on
      n.sync_q = rx_in.sync_hunt;
      if (rd_rx && q.rxc[RC_SYNC_IE])
         n.sync_chg = 1'b0;
      if (rx_in.sync_hunt != q.sync_q)
         n.sync_chg = 1'b1;
      // Overrun and receiver stop
      if (rx_spec_cmd)
      begin
         n.overrun = 1'b0;
         n.rx_en = 1'b1;
      end
      if (rx_in.overflow)
      begin
         n.overrun = 1'b1;
         n.rx_en = 1'b0;
      end
      // Status extension for the entry being written
      n.entry_st = {rx_in.abort_det,
         rx_in.align_err || (rx_in.crc_bad && q.rxc[RC_CRC_EN]),
         rx_in.eof_det};
      // Receive ready threshold
      n.rx_ready = q.rxc[RC_THR_SEL] ? (rx_in.fifo_level > RX_HALF)
         : (rx_in.fifo_level != 5'd0);
      // Receive interrupt
      n.rx_irq = (q.rxc[RC_READY_IE] && q.rx_ready)
         || (q.rxc[RC_SYNC_IE] && q.sync_chg)
         || (q.rxc[RC_SPEC_IE] && (q.overrun || (rx_in.top_status != 3'h0)));
   end

   // State register
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         q <= '0;
         q.tc1 <= TX_CTL1_RST;
         q.tc2 <= TX_CTL2_RST;
         q.rxc <= RX_CTL_RST;
         q.misc <= MISC_RST;
         q.ready_q <= 1'b1;
         q.rx_en <= 1'b1;
      end
      else
         q <= n;
   end

   // Outputs from flops
   assign rdata_out = q.rdata;
   assign tx_dma_start_out = q.dma_start;
   assign tx_irq_out = q.tx_irq;
   assign rx_enable_out = q.rx_en;
   assign rx_crc_check_en_out = q.rxc[RC_CRC_EN];
   assign rx_addr_mode_out = q.rxc[RC_AMODE+1:RC_AMODE];
   assign rx_entry_status_out = q.entry_st;
   assign rx_queue_ready_out = q.rx_ready;
   assign rx_irq_out = q.rx_irq;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (srst_in);

   sequence done_drop_s;
      q.done && !n.done && q.misc[MISC_TX_EN] && q.misc[MISC_DMA_CONN];
   endsequence

   sequence tx_read_s;
      bus_in.rd && (bus_in.addr == ADDR_TX_STAT);
   endsequence

   // Early flag on crossing the level
   early_set_a: assert property (ew_hit |=> q.early)
      else $error("early flag not set on level");
   // Early flag visible then cleared by the read
   early_read_a: assert property (q.early && !ew_hit ##0 tx_read_s
      |=> rdata_out[0] && !q.early)
      else $error("early flag read or clear wrong");
   // Underrun sets and holds
   underrun_set_a: assert property (tx_in.fifo_empty && tx_in.byte_count != 11'h000
      |=> q.underrun)
      else $error("underrun not set");
   underrun_hold_a: assert property (q.underrun && !clr_tx_cmd |=> q.underrun)
      else $error("underrun dropped without command");
   // Auto clear of done on status read
   done_auto_a: assert property (tx_read_s ##0 q.tc1[TC1_AUTO_CLR]
      && !tx_in.packet_done && !clr_tx_cmd |=> !q.done)
      else $error("done not auto cleared");
   // Done stays without auto clear or command
   done_keep_a: assert property (q.done && !clr_tx_cmd && !q.tc1[TC1_AUTO_CLR]
      |=> q.done)
      else $error("done dropped unexpectedly");
   // DMA start pulses for one cycle, in the same cycle that done falls
   dma_start_a: assert property (done_drop_s |=> tx_dma_start_out ##1 !tx_dma_start_out)
      else $error("dma start pulse wrong");
   // Receiver stays stopped until the special reset
   rx_stop_a: assert property (rx_in.overflow |=> !rx_enable_out)
      else $error("receiver not stopped on overflow");
   rx_hold_a: assert property (!rx_enable_out && !rx_spec_cmd |=> !rx_enable_out)
      else $error("receiver restarted without command");
   // CRC errors masked when checking is off
   crc_mask_a: assert property (!q.rxc[RC_CRC_EN] && !rx_in.align_err
      |=> !rx_entry_status_out[1])
      else $error("crc error reported while disabled");
   // Receive status read shows overrun, and bit 0 reads zero
   rx_read_a: assert property (bus_in.rd && bus_in.addr == ADDR_RX_STAT
      |=> rdata_out[5] == $past(q.overrun) && rdata_out[0] == 1'b0)
      else $error("receive status read wrong");
endmodule

// >>> rtl/firsc_pkg.sv
// Constants, types and register map of the fast infrared status and control bank
// What this block does
// - Three-bit early warning level in transmit control two picks the remaining count.
// - Level code zero gives no early warning; done itself raises the interrupt.
// - Codes one, two, three warn at 16, 32 and 64 bytes remaining.
// - Code four warns at 128 bytes, code seven at 1042 bytes.
// - Code six warns when 512 bytes remain.
// - Transmit status is read-only at index 5: underrun, done, ready, early.
// - Underrun sets on empty queue with count above zero, held until command.
// - Packet done sets after CRC and closing flag are sent.
// - With auto clear enabled, reading transmit status clears packet done.
// - The clear command in the reset command register also clears packet done.
// - Packet done clearing starts next DMA when transmit enabled and DMA connected.
// - Queue ready follows not-full; its interrupt fires on becoming true if enabled.
// - Early flag sets when count reaches level and clears on status read.
// - Receive control at index 6 holds threshold, CRC, address mode, interrupt enables.
// - Receive status is read-only at index 7 with the documented bit layout.
// - Abort, frame error and end go to a 3-bit entry extension; reads do not pop.
// - Receive queue overflow stops reception until the special condition reset command.
package firsc_pkg;
   // Register indices in bank 0
   localparam logic [3:0] ADDR_MISC = 4'h2;
   localparam logic [3:0] ADDR_TX_CTL1 = 4'h3;
   localparam logic [3:0] ADDR_TX_CTL2 = 4'h4;
   localparam logic [3:0] ADDR_TX_STAT = 4'h5;
   localparam logic [3:0] ADDR_RX_CTL = 4'h6;
   localparam logic [3:0] ADDR_RX_STAT = 4'h7;
   localparam logic [3:0] ADDR_RST_CMD = 4'h7;
   // Reset values and write masks
   localparam logic [7:0] TX_CTL1_RST = 8'h00;
   localparam logic [7:0] TX_CTL2_RST = 8'h40;
   localparam logic [7:0] RX_CTL_RST = 8'h00;
   localparam logic [7:0] MISC_RST = 8'h00;
   localparam logic [7:0] RX_CTL_MASK = 8'hfb;
   localparam logic [7:0] MISC_MASK = 8'h03;
   // Field positions
   localparam int TC1_READY_IE = 6;
   localparam int TC1_DONE_IE = 5;
   localparam int TC1_AUTO_CLR = 2;
   localparam int RC_THR_SEL = 7;
   localparam int RC_CRC_EN = 6;
   localparam int RC_AMODE = 4;
   localparam int RC_SYNC_IE = 3;
   localparam int RC_READY_IE = 1;
   localparam int RC_SPEC_IE = 0;
   localparam int MISC_TX_EN = 0;
   localparam int MISC_DMA_CONN = 1;
   localparam int CMD_POS = 4;
   // Reset command codes
   localparam logic [3:0] CMD_CLR_TX = 4'h1;
   localparam logic [3:0] CMD_RX_SPECIAL = 4'h2;
   // Early warning counts per level code
   localparam logic [10:0] EW_CNT_1 = 11'd16;
   localparam logic [10:0] EW_CNT_2 = 11'd32;
   localparam logic [10:0] EW_CNT_3 = 11'd64;
   localparam logic [10:0] EW_CNT_4 = 11'd128;
   localparam logic [10:0] EW_CNT_5 = 11'd256;
   localparam logic [10:0] EW_CNT_6 = 11'd512;
   localparam logic [10:0] EW_CNT_7 = 11'd1042;
   // Receive queue half-full level
   localparam logic [4:0] RX_HALF = 5'd8;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } firsc_bus_t;

   typedef struct packed {
      logic fifo_empty;
      logic fifo_full;
      logic [10:0] byte_count;
      logic packet_done;
   } firsc_tx_in_t;

   typedef struct packed {
      logic [4:0] fifo_level;
      logic [2:0] top_status;
      logic overflow;
      logic sync_hunt;
      logic abort_det;
      logic align_err;
      logic crc_bad;
      logic eof_det;
   } firsc_rx_in_t;

   typedef struct packed {
      logic [7:0] tc1;
      logic [7:0] tc2;
      logic [7:0] rxc;
      logic [7:0] misc;
      logic underrun;
      logic done;
      logic early;
      logic ready_evt;
      logic ready_q;
      logic sync_chg;
      logic sync_q;
      logic overrun;
      logic rx_en;
      logic [10:0] prev_cnt;
      logic pin_s1;
      logic pin_s2;
      logic [7:0] rdata;
      logic dma_start;
      logic tx_irq;
      logic rx_irq;
      logic [2:0] entry_st;
      logic rx_ready;
   } firsc_state_t;
endpackage

// >>> dv/firsc_far.sv
// Behavioural transmit and receive datapath facing the status bank
module firsc_far
(
   // Clock
   input wire logic sys_clk_in,
   // Datapath status toward the bank
   output firsc_pkg::firsc_tx_in_t tx_out,
   output firsc_pkg::firsc_rx_in_t rx_out,
   output logic pin_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import firsc_pkg::*;

   // Idle datapath: queue neither empty nor full, line at rest high
   initial
   begin
      tx_out = '0;
      rx_out = '0;
      pin_out = 1'b1;
   end

   // Queue levels and remaining count change just after an edge
   task automatic set_tx(input logic empty, input logic full, input logic [10:0] cnt);
      @(posedge sys_clk_in);
      tx_out.fifo_empty <= empty;
      tx_out.fifo_full <= full;
      tx_out.byte_count <= cnt;
   endtask

   // One-cycle completion after CRC and closing flag
   task automatic pulse_done();
      @(posedge sys_clk_in);
      tx_out.packet_done <= 1'b1;
      @(posedge sys_clk_in);
      tx_out.packet_done <= 1'b0;
   endtask

   // Receive queue fill, top entry status and byte under check
   task automatic set_rx(input logic [4:0] lvl, input logic [2:0] top, input logic crc);
      @(posedge sys_clk_in);
      rx_out.fifo_level <= lvl;
      rx_out.top_status <= top;
      rx_out.crc_bad <= crc;
   endtask

   // One-cycle receive queue overflow
   task automatic pulse_ovf();
      @(posedge sys_clk_in);
      rx_out.overflow <= 1'b1;
      @(posedge sys_clk_in);
      rx_out.overflow <= 1'b0;
   endtask

   // Receive line level and internal sync signal change just after an edge
   task automatic set_lines(input logic pin, input logic sync);
      @(posedge sys_clk_in);
      pin_out <= pin;
      rx_out.sync_hunt <= sync;
   endtask
endmodule

// >>> dv/fast_ir_tx_rx_status_control_tb.sv
// Self-checking bench of the fast infrared status and control bank
module fast_ir_tx_rx_status_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import firsc_pkg::*;

   localparam logic [10:0] EWC [8] = '{11'd0, 11'd16, 11'd32, 11'd64, 11'd128, 11'd256,
      11'd512, 11'd1042};
   logic sys_clk_in = 1'b0;
   logic srst_in = 1'b1;
   firsc_bus_t bus = '0;
   firsc_tx_in_t tx;
   firsc_rx_in_t rx;
   logic pin, dma, tx_irq, rx_en, crc_en, rx_rdy, rx_irq;
   int n_dma = 0;
   logic [7:0] rdata;
   logic [1:0] amode;
   logic [2:0] entry;
   int n_errors = 0;
   int num_checks = 0;
   int cycles = 0;

   // Clock and hang limit
   always #50 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         conclude();
      end
   end

   // Count DMA start pulses mid-cycle, where the pulse has settled
   always @(negedge sys_clk_in)
   begin
      if (dma === 1'b1)
         n_dma++;
   end

   firsc_far i_far (.sys_clk_in(sys_clk_in), .tx_out(tx), .rx_out(rx), .pin_out(pin));

   firsc_top i_dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .bus_in(bus),
      .rdata_out(rdata), .tx_in(tx), .tx_dma_start_out(dma), .tx_irq_out(tx_irq),
      .rx_in(rx), .rx_pin_in(pin), .rx_enable_out(rx_en), .rx_crc_check_en_out(crc_en),
      .rx_addr_mode_out(amode), .rx_entry_status_out(entry),
      .rx_queue_ready_out(rx_rdy), .rx_irq_out(rx_irq));

   // Comparison and verdict
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Register port cycles
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk_in);
      bus.wr <= 1'b0;
   endtask

   task automatic expect_rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk_in);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk_in);
      bus.rd <= 1'b0;
      #1 check(rdata, exp);
   endtask

   // Main sequence
   initial
   begin
      repeat (12) @(posedge sys_clk_in);
      srst_in <= 1'b0;
      expect_rd(ADDR_TX_CTL2, 8'h40);
      expect_rd(4'h0, 8'h00);
      reg_wr(ADDR_TX_STAT, 8'hff);
      expect_rd(ADDR_TX_STAT, 8'h02);
      check(8'(rx_en), 8'h01);
      for (int c = 1; c < 8; c++)
      begin
         reg_wr(ADDR_TX_CTL2, 8'h40 | 8'(c));
         i_far.set_tx(1'b0, 1'b0, EWC[c] + 11'd1);
         i_far.set_tx(1'b0, 1'b0, EWC[c]);
         cyc(2);
         expect_rd(ADDR_TX_STAT, 8'h03);
         expect_rd(ADDR_TX_STAT, 8'h02);
      end
      // Level zero: no warning, completion itself interrupts
      reg_wr(ADDR_TX_CTL2, 8'h40);
      reg_wr(ADDR_TX_CTL1, 8'h20);
      i_far.set_tx(1'b0, 1'b0, 11'd17);
      i_far.set_tx(1'b0, 1'b0, 11'd16);
      cyc(2);
      expect_rd(ADDR_TX_STAT, 8'h02);
      i_far.pulse_done();
      cyc(3);
      check(8'(tx_irq), 8'h01);
      expect_rd(ADDR_TX_STAT, 8'h06);
      expect_rd(ADDR_TX_STAT, 8'h06);
      reg_wr(ADDR_RST_CMD, 8'h10);
      cyc(6);
      check(8'(n_dma), 8'h00);
      expect_rd(ADDR_TX_STAT, 8'h02);
      check(8'(tx_irq), 8'h00);
      // Auto clear on read restarts DMA; DMA is connected first
      reg_wr(ADDR_MISC, 8'h03);
      reg_wr(ADDR_TX_CTL1, 8'h04);
      i_far.pulse_done();
      expect_rd(ADDR_TX_STAT, 8'h06);
      cyc(6);
      check(8'(n_dma), 8'h01);
      expect_rd(ADDR_TX_STAT, 8'h02);
      // Underrun holds until the clear command
      i_far.set_tx(1'b1, 1'b0, 11'd5);
      i_far.set_tx(1'b0, 1'b0, 11'd5);
      cyc(2);
      expect_rd(ADDR_TX_STAT, 8'h0a);
      expect_rd(ADDR_TX_STAT, 8'h0a);
      reg_wr(ADDR_RST_CMD, 8'h10);
      expect_rd(ADDR_TX_STAT, 8'h02);
      // Queue ready and its interrupt
      reg_wr(ADDR_TX_CTL1, 8'h40);
      i_far.set_tx(1'b0, 1'b1, 11'd5);
      cyc(2);
      expect_rd(ADDR_TX_STAT, 8'h00);
      i_far.set_tx(1'b0, 1'b0, 11'd5);
      cyc(3);
      check(8'(tx_irq), 8'h01);
      // Receive control fields
      reg_wr(ADDR_RX_CTL, 8'hff);
      expect_rd(ADDR_RX_CTL, 8'hfb);
      check({5'h00, crc_en, amode}, 8'h07);
      i_far.set_rx(5'd9, 3'b101, 1'b1);
      cyc(3);
      check({4'h0, entry, rx_rdy}, 8'h05);
      expect_rd(ADDR_RX_STAT, 8'h9a);
      i_far.set_rx(5'd8, 3'b101, 1'b1);
      cyc(3);
      check(8'(rx_rdy), 8'h00);
      reg_wr(ADDR_RX_CTL, 8'h01);
      cyc(3);
      check({4'h0, entry, rx_rdy}, 8'h01);
      check(8'(rx_irq), 8'h01);
      reg_wr(ADDR_RX_CTL, 8'h00);
      cyc(3);
      check(8'(rx_irq), 8'h00);
      expect_rd(ADDR_RX_STAT, 8'h9a);
      // Overflow stops reception until the special reset
      i_far.pulse_ovf();
      cyc(2);
      check(8'(rx_en), 8'h00);
      expect_rd(ADDR_RX_STAT, 8'hba);
      reg_wr(ADDR_RST_CMD, 8'h20);
      cyc(2);
      check(8'(rx_en), 8'h01);
      // Line level and sync change, live first, then latched with its interrupt
      i_far.set_lines(1'b0, 1'b1);
      cyc(3);
      expect_rd(ADDR_RX_STAT, 8'h9c);
      reg_wr(ADDR_RX_CTL, 8'h08);
      cyc(3);
      check(8'(rx_irq), 8'h01);
      expect_rd(ADDR_RX_STAT, 8'h9c);
      expect_rd(ADDR_RX_STAT, 8'h98);
      conclude();
   end
endmodule
